// ### core/pic_regs.svh
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH
`define PIC_NUM_IRQ      28
`define PIC_PRIO_W       3
`define PIC_IDX_W        5
`define PIC_EFF_W        4
`define PIC_NMI_NUM      5'h1c
`define PIC_EFF_NMI      4'h0
`define PIC_EFF_IDLE     4'hf
`define PIC_ENTRY_CYC    12
`define PIC_TAIL_CYC     6
`define PIC_CNT_W        4
`define PIC_OP_ENABLE    2'h0
`define PIC_OP_PRIO      2'h1
`define PIC_OP_SETPEND   2'h2
`define PIC_OP_CLRPEND   2'h3
`define PIC_SIZE_BAD     2'h3
`endif

// ### core/pic_pkg.sv
`include "pic_regs.svh"
package pic_pkg;
   typedef struct packed {
      logic                     valid;
      logic                     write;
      logic                     priv;
      logic [1:0]               op;
      logic [1:0]               size;
      logic [`PIC_IDX_W-1:0]    idx;
      logic [31:0]              wdata;
   } pic_acc_t;
   typedef enum logic [0:0] {
      PIC_ST_IDLE,
      PIC_ST_ENTRY
   } pic_state_t;
endpackage : pic_pkg

// ### core/pic_nested_vector_irq_unit.sv
`timescale 1ns/10ps
// Summary of operation
// - 28 requests, eight programmable priority levels
// - Full access only from privileged mode
// - User pend allowed when configuration enables
// - Other user access faults the bus
// - Byte, halfword and word accesses accepted
// - External NMI input, never masked
// - Oscillator check fault raises NMI
// - Entry 12 cycles, tail-chained 6
// - Track active nested exceptions for preemption and return
`include "pic_regs.svh"
module pic_nested_vector_irq_unit
   import pic_pkg::*;
(
   input  wire logic                      CLOCK_I,
   input  wire logic                      ARST_N_I,
   input  wire logic [`PIC_NUM_IRQ-1:0]   IRQ_I,
   input  wire logic                      NMI_PIN_I,
   input  wire logic                      OSC_FAULT_I,
   input  wire logic                      WDOG_NMI_I,
   input  wire logic                      USER_PEND_EN_I,
   input  wire pic_acc_t                  ACC_I,
   output logic                           ACC_DONE_O,
   output logic                           ACC_FAULT_O,
   output logic [31:0]                    ACC_RDATA_O,
   input  wire logic                      EXC_RETURN_I,
   output logic                           EXC_START_O,
   output logic                           EXC_TAIL_O,
   output logic [`PIC_IDX_W-1:0]          EXC_NUM_O,
   output logic [`PIC_NUM_IRQ:0]          ACTIVE_O
);
   localparam int NSRC = `PIC_NUM_IRQ + 1;

   logic [`PIC_NUM_IRQ-1:0]   enable_reg;
   logic [`PIC_PRIO_W-1:0]    prio_reg [`PIC_NUM_IRQ];
   logic [NSRC-1:0]           pend_reg;
   logic [NSRC-1:0]           active_reg;
   pic_state_t                state_reg;
   logic [`PIC_CNT_W-1:0]     cnt_reg;
   logic [`PIC_IDX_W-1:0]     sel_reg;
   logic                      tail_reg;
   logic                      chain_reg;

   // Effective priority: NMI is 0, peripheral levels shifted up by one
   logic [`PIC_EFF_W-1:0]     eff      [NSRC];
   logic [NSRC-1:0]           cand;
   logic [NSRC-1:0]           set_src;
   logic [NSRC-1:0]           pend_next;

   // Access port checks, ahead of the source loop that reads them
   wire idx_ok  = ACC_I.idx < `PIC_NUM_IRQ;
   wire size_ok = ACC_I.size != `PIC_SIZE_BAD;
   wire user_ok = USER_PEND_EN_I & ACC_I.write & (ACC_I.op == `PIC_OP_SETPEND);
   wire priv_ok = ACC_I.priv | user_ok;
   wire acc_ok  = ACC_I.valid & idx_ok & size_ok & priv_ok;
   wire acc_bad = ACC_I.valid & ~acc_ok;
   wire acc_wr  = acc_ok & ACC_I.write;

   genvar g;
   generate
      for (g = 0; g < `PIC_NUM_IRQ; g++) begin : g_src
         assign eff[g]     = {1'b0, prio_reg[g]} + 4'h1;
         assign cand[g]    = pend_reg[g] & enable_reg[g];
         assign set_src[g] = IRQ_I[g] | (acc_ok & (ACC_I.op == `PIC_OP_SETPEND)
                                         & ACC_I.write & (ACC_I.idx == g));
      end
   endgenerate
   assign eff[`PIC_NUM_IRQ]     = `PIC_EFF_NMI;
   assign cand[`PIC_NUM_IRQ]    = pend_reg[`PIC_NUM_IRQ];
   assign set_src[`PIC_NUM_IRQ] = NMI_PIN_I | OSC_FAULT_I | WDOG_NMI_I;

   // Lowest value wins, lowest number on ties
   logic [`PIC_EFF_W-1:0]     best_eff;
   logic [`PIC_IDX_W-1:0]     best_idx;
   logic [`PIC_EFF_W-1:0]     run_eff;
   logic [`PIC_IDX_W-1:0]     run_idx;
   always_comb begin
      best_eff = `PIC_EFF_IDLE;
      best_idx = '0;
      run_eff  = `PIC_EFF_IDLE;
      run_idx  = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (cand[i] && eff[i] <= best_eff) begin
            best_eff = eff[i];
            best_idx = i[`PIC_IDX_W-1:0];
         end
         if (active_reg[i] && eff[i] <= run_eff) begin
            run_eff = eff[i];
            run_idx = i[`PIC_IDX_W-1:0];
         end
      end
   end

   wire preempt = (best_eff < run_eff) && (best_eff != `PIC_EFF_IDLE);
   wire go      = (state_reg == PIC_ST_IDLE) && preempt;
   wire fin     = (state_reg == PIC_ST_ENTRY) && (cnt_reg == '0);
   wire ret     = EXC_RETURN_I && (active_reg != '0);

   logic [31:0] rd_next;
   always_comb begin
      rd_next = '0;
      if (!ACC_I.valid || !idx_ok) begin
         rd_next = '0;
      end else if (ACC_I.op == `PIC_OP_ENABLE) begin
         rd_next[0] = enable_reg[ACC_I.idx];
      end else if (ACC_I.op == `PIC_OP_PRIO) begin
         rd_next[`PIC_PRIO_W-1:0] = prio_reg[ACC_I.idx];
      end else begin
         rd_next[0] = pend_reg[ACC_I.idx];
      end
   end

   // Set beats clear; taking an exception clears its pending bit
   always_comb begin
      pend_next = pend_reg;
      if (acc_wr && ACC_I.op == `PIC_OP_CLRPEND) begin
         pend_next[ACC_I.idx] = 1'b0;
      end
      if (go) begin
         pend_next[best_idx] = 1'b0;
      end
      pend_next = pend_next | set_src;
   end

   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         enable_reg <= '0;
         pend_reg   <= '0;
      end else begin
         pend_reg <= pend_next;
         if (acc_wr && ACC_I.op == `PIC_OP_ENABLE) begin
            enable_reg[ACC_I.idx] <= ACC_I.wdata[0];
         end
      end
   end

   generate
      for (g = 0; g < `PIC_NUM_IRQ; g++) begin : g_prio
         always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
               prio_reg[g] <= '0;
            end else if (acc_wr && ACC_I.op == `PIC_OP_PRIO && ACC_I.idx == g) begin
               prio_reg[g] <= ACC_I.wdata[`PIC_PRIO_W-1:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ACC_DONE_O  <= 1'b0;
         ACC_FAULT_O <= 1'b0;
         ACC_RDATA_O <= '0;
      end else begin
         ACC_DONE_O  <= ACC_I.valid;
         ACC_FAULT_O <= acc_bad;
         ACC_RDATA_O <= acc_ok ? rd_next : '0;
      end
   end

   // Entry sequencer; count preload leaves handler start on the exact cycle
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_reg   <= PIC_ST_IDLE;
         cnt_reg     <= '0;
         sel_reg     <= '0;
         tail_reg    <= 1'b0;
         chain_reg   <= 1'b0;
         active_reg  <= '0;
         EXC_START_O <= 1'b0;
         EXC_TAIL_O  <= 1'b0;
         EXC_NUM_O   <= '0;
      end else begin
         EXC_START_O <= fin;
         tail_reg    <= ret;
         case (state_reg)
            PIC_ST_IDLE: begin
               if (go) begin
                  state_reg <= PIC_ST_ENTRY;
                  sel_reg   <= best_idx;
                  chain_reg <= tail_reg;
                  cnt_reg   <= tail_reg ? `PIC_CNT_W'(`PIC_TAIL_CYC - 2)
                                        : `PIC_CNT_W'(`PIC_ENTRY_CYC - 2);
               end
            end
            PIC_ST_ENTRY: begin
               if (fin) begin
                  state_reg <= PIC_ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - `PIC_CNT_W'(1);
               end
            end
            default: state_reg <= PIC_ST_IDLE;
         endcase
         if (fin) begin
            EXC_NUM_O  <= sel_reg;
            EXC_TAIL_O <= chain_reg;
         end
         // Return retires the innermost handler; others stay stacked
         if (ret) begin
            active_reg[run_idx] <= 1'b0;
         end
         if (fin) begin
            active_reg[sel_reg] <= 1'b1;
         end
      end
   end

   assign ACTIVE_O = active_reg;

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!ARST_N_I);

   property p_entry12;
      go && !tail_reg |-> ##11 !EXC_START_O ##1 EXC_START_O && !EXC_TAIL_O;
   endproperty
   a_entry12: assert property (p_entry12) else $error("entry not 12 cycles");
   property p_tail6;
      go && tail_reg |-> ##5 !EXC_START_O ##1 EXC_START_O && EXC_TAIL_O;
   endproperty
   a_tail6: assert property (p_tail6) else $error("tail entry not 6 cycles");
   property p_nmi_pend;
      NMI_PIN_I |=> pend_reg[`PIC_NUM_IRQ] || state_reg == PIC_ST_ENTRY;
   endproperty
   a_nmi_pend: assert property (p_nmi_pend) else $error("nmi pin lost");
   property p_osc_nmi;
      OSC_FAULT_I && !go |=> pend_reg[`PIC_NUM_IRQ];
   endproperty
   a_osc_nmi: assert property (p_osc_nmi) else $error("osc fault lost");
   property p_user_fault;
      ACC_I.valid && !ACC_I.priv && !(USER_PEND_EN_I && ACC_I.write
         && ACC_I.op == `PIC_OP_SETPEND) |=> ACC_FAULT_O && ACC_DONE_O;
   endproperty
   a_user_fault: assert property (p_user_fault) else $error("user access not faulted");
   property p_user_pend;
      ACC_I.valid && !ACC_I.priv && USER_PEND_EN_I && ACC_I.write && idx_ok
         && ACC_I.op == `PIC_OP_SETPEND && ACC_I.size != `PIC_SIZE_BAD |=> !ACC_FAULT_O;
   endproperty
   a_user_pend: assert property (p_user_pend) else $error("user pend refused");
   property p_priv_ok;
      ACC_I.valid && ACC_I.priv && idx_ok && ACC_I.size != `PIC_SIZE_BAD |=> !ACC_FAULT_O;
   endproperty
   a_priv_ok: assert property (p_priv_ok) else $error("privileged access faulted");
   property p_preempt;
      state_reg == PIC_ST_IDLE && cand[`PIC_NUM_IRQ] && !active_reg[`PIC_NUM_IRQ]
         |-> go && best_idx == `PIC_NMI_NUM;
   endproperty
   a_preempt: assert property (p_preempt) else $error("pending nmi not taken");
   property p_active;
      EXC_START_O |-> active_reg[EXC_NUM_O];
   endproperty
   a_active: assert property (p_active) else $error("started handler not active");
   property p_prio_wr;
      acc_wr && ACC_I.op == `PIC_OP_PRIO |=> prio_reg[$past(ACC_I.idx)]
         == $past(ACC_I.wdata[`PIC_PRIO_W-1:0]);
   endproperty
   a_prio_wr: assert property (p_prio_wr) else $error("priority write lost");

   c_tail: cover property (EXC_START_O && EXC_TAIL_O);
   c_nest: cover property (EXC_START_O && active_reg != (NSRC'(1) << EXC_NUM_O));
   c_fault: cover property (ACC_FAULT_O);
endmodule : pic_nested_vector_irq_unit

// ### dv/pic_core_model.sv
`timescale 1ns/10ps
module pic_core_model (
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       exc_start_i,
   input  wire logic       active_any_i,
   input  wire logic [7:0] hold_i,
   output logic            exc_return_o
);
   logic [7:0] cnt_reg;
   // Each handler body lasts hold_i cycles; a new entry restarts the body
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_reg      <= 8'h00;
         exc_return_o <= 1'b0;
      end else begin
         exc_return_o <= 1'b0;
         if (exc_start_i) begin
            cnt_reg <= hold_i;
         end else if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
         end else if (cnt_reg == 8'h01) begin
            // Outer handlers resume and return in turn
            cnt_reg      <= active_any_i ? hold_i : 8'h00;
            exc_return_o <= active_any_i;
         end
      end
   end
endmodule : pic_core_model

// ### dv/prioritized_interrupt_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "pic_regs.svh"
module prioritized_interrupt_ctrl_tb_top
   import pic_pkg::*;
;
   logic        clk, rst_n, nmi_pin, osc_fault, wdog_nmi, user_en;
   logic        ret, done, fault, start, tail;
   logic [27:0] irq;
   logic [4:0]  num;
   logic [28:0] active;
   logic [31:0] rdata;
   logic [7:0]  hold;
   pic_acc_t    acc;
   int          error_cnt;
   int          compares;

   pic_nested_vector_irq_unit dut (.CLOCK_I(clk), .ARST_N_I(rst_n), .IRQ_I(irq),
      .NMI_PIN_I(nmi_pin), .OSC_FAULT_I(osc_fault), .WDOG_NMI_I(wdog_nmi),
      .USER_PEND_EN_I(user_en), .ACC_I(acc), .ACC_DONE_O(done), .ACC_FAULT_O(fault),
      .ACC_RDATA_O(rdata), .EXC_RETURN_I(ret), .EXC_START_O(start), .EXC_TAIL_O(tail),
      .EXC_NUM_O(num), .ACTIVE_O(active));
   pic_core_model u_core (.clk_i(clk), .arst_n_i(rst_n), .exc_start_i(start),
      .active_any_i(|active), .hold_i(hold), .exc_return_o(ret));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic access(input logic wr, input logic pv, input logic [1:0] op,
                         input logic [1:0] sz, input logic [4:0] idx,
                         input logic [31:0] wd, input logic exp_f);
      @(posedge clk);
      #1;
      acc = '{1'b1, wr, pv, op, sz, idx, wd};
      @(posedge clk);
      #1;
      acc.valid = 1'b0;
      chk(32'(done), 32'h1);
      chk(32'(fault), 32'(exp_f));
   endtask : access

   task automatic cfg(input logic [4:0] idx, input logic [2:0] pr);
      access(1'b1, 1'b1, `PIC_OP_PRIO, 2'h2, idx, {29'h0, pr}, 1'b0);
      access(1'b1, 1'b1, `PIC_OP_ENABLE, 2'h2, idx, 32'h1, 1'b0);
   endtask : cfg

   // Request sources: {watchdog, oscillator check, pin, peripherals}
   task automatic pulse(input logic [30:0] m);
      @(posedge clk);
      #1;
      {wdog_nmi, osc_fault, nmi_pin, irq} = m;
      @(posedge clk);
      #1;
      {wdog_nmi, osc_fault, nmi_pin, irq} = 31'h0;
   endtask : pulse

   task automatic wait_start(input int exp_n, input logic [4:0] exp_num);
      int n;
      n = 0;
      while (start !== 1'b1 && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(32'(n), 32'(exp_n));
      chk(32'(num), 32'(exp_num));
      chk(32'(tail), 32'(exp_n < 12));
   endtask : wait_start

   task automatic wait_ret();
      int n;
      n = 0;
      while (ret !== 1'b1 && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(32'(ret), 32'h1);
   endtask : wait_ret

   task automatic t_access();
      for (int s = 0; s < 3; s++) begin
         access(1'b1, 1'b1, `PIC_OP_PRIO, 2'(s), 5'h3, 32'(5 + s), 1'b0);
         access(1'b0, 1'b1, `PIC_OP_PRIO, 2'(s), 5'h3, 32'h0, 1'b0);
         chk(32'(rdata[2:0]), 32'(5 + s));
      end
      access(1'b1, 1'b1, `PIC_OP_PRIO, `PIC_SIZE_BAD, 5'h3, 32'h1, 1'b1);
      access(1'b1, 1'b1, `PIC_OP_PRIO, 2'h2, 5'h1c, 32'h1, 1'b1);
      user_en = 1'b0;
      access(1'b1, 1'b0, `PIC_OP_SETPEND, 2'h2, 5'h3, 32'h0, 1'b1);
      user_en = 1'b1;
      access(1'b1, 1'b0, `PIC_OP_PRIO, 2'h2, 5'h3, 32'h1, 1'b1);
      access(1'b0, 1'b0, `PIC_OP_PRIO, 2'h2, 5'h3, 32'h0, 1'b1);
      access(1'b1, 1'b0, `PIC_OP_SETPEND, 2'h0, 5'h3, 32'h0, 1'b0);
      access(1'b0, 1'b1, `PIC_OP_SETPEND, 2'h2, 5'h3, 32'h0, 1'b0);
      chk(32'(rdata[0]), 32'h1);
      access(1'b0, 1'b1, `PIC_OP_PRIO, 2'h2, 5'h3, 32'h0, 1'b0);
      chk(32'(rdata[2:0]), 32'h7);
      access(1'b1, 1'b1, `PIC_OP_CLRPEND, 2'h1, 5'h3, 32'h0, 1'b0);
      access(1'b0, 1'b1, `PIC_OP_SETPEND, 2'h2, 5'h3, 32'h0, 1'b0);
      chk(32'(rdata[0]), 32'h0);
   endtask : t_access

   task automatic t_entry();
      hold = 8'd30;
      cfg(5'h2, 3'h4);
      cfg(5'h5, 3'h4);
      pulse(31'h4);
      wait_start(12, 5'h2);
      chk(32'(active), 32'h4);
      // Equal value must wait, then tail-chain off the return
      pulse(31'h20);
      wait_ret();
      wait_start(7, 5'h5);
      chk(32'(tail), 32'h1);
      wait_ret();
   endtask : t_entry

   task automatic t_nmi();
      hold = 8'd5;
      for (int k = 0; k < 3; k++) begin
         pulse(31'h1000_0000 << k);
         wait_start(12, `PIC_NMI_NUM);
         chk(32'(active[28]), 32'h1);
         wait_ret();
         repeat (3) @(posedge clk);
      end
   endtask : t_nmi

   task automatic t_prio();
      hold = 8'd20;
      cfg(5'h7, 3'h3);
      cfg(5'h9, 3'h2);
      cfg(5'h8, 3'h2);
      pulse(31'h380);
      wait_start(12, 5'h8);
      wait_ret();
      wait_start(7, 5'h9);
      wait_ret();
      wait_start(7, 5'h7);
      // Strictly lower value preempts and nests
      pulse(31'h100);
      wait_start(12, 5'h8);
      chk(32'(active), 32'h180);
   endtask : t_prio

   // Mid-run reset while two handlers are stacked
   task automatic t_reset();
      @(posedge clk);
      #1;
      rst_n = 1'b0;
      @(posedge clk);
      #1;
      chk(32'(active), 32'h0);
      chk(32'(num), 32'h0);
      chk(32'(start), 32'h0);
      @(posedge clk);
      #1;
      rst_n = 1'b1;
      access(1'b0, 1'b1, `PIC_OP_ENABLE, 2'h2, 5'h8, 32'h0, 1'b0);
      chk(32'(rdata), 32'h0);
      access(1'b0, 1'b1, `PIC_OP_PRIO, 2'h0, 5'h8, 32'h0, 1'b0);
      chk(32'(rdata), 32'h0);
   endtask : t_reset

   task automatic tally_and_finish();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   initial begin
      #60000;
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      error_cnt = 0;
      compares = 0;
      rst_n = 1'b0;
      {wdog_nmi, osc_fault, nmi_pin, irq} = 31'h0;
      user_en = 1'b0;
      hold = 8'd10;
      acc = '0;
      repeat (4) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_access();
      t_entry();
      t_nmi();
      t_prio();
      t_reset();
      tally_and_finish();
   end
endmodule : prioritized_interrupt_ctrl_tb_top
